// ===== adcdc_pkg.sv
// Package with the register map, field layout, reset values and carrier types of the ADC digital comparator
package adcdc_pkg;

	// Input numbering
	localparam int          NUM_INPUTS   = 45;
	localparam logic [5:0]  MAX_INPUT    = 6'h2c;   // Highest legal monitored-input code
	localparam logic [5:0]  NORMAL_LIMIT = 6'h20;   // Normal mode watches inputs below this
	localparam int          RES_BITS     = 12;      // Width of one raw conversion

	// Register byte addresses
	localparam logic [11:0] OFS_CMP_CTRL    = 12'h000;
	localparam logic [11:0] OFS_LIMITS      = 12'h004;
	localparam logic [11:0] OFS_CONV_CTRL   = 12'h008;
	localparam logic [3:0]  OFS_RESULT_PAGE = 4'h1;   // Results at 0x100 + 4 * input

	// Comparator control fields
	localparam int CTRL_DIFF_LSB = 16;
	localparam int CTRL_ID_LSB   = 8;
	localparam int CTRL_EN_BIT   = 7;
	localparam int CTRL_GIEN_BIT = 6;
	localparam int CTRL_FLAG_BIT = 5;
	localparam int CTRL_BTWN_BIT = 4;
	localparam int CTRL_HIHI_BIT = 3;
	localparam int CTRL_HILO_BIT = 2;
	localparam int CTRL_LOHI_BIT = 1;
	localparam int CTRL_LOLO_BIT = 0;

	// Limit and converter control fields
	localparam int LIM_HI_LSB     = 16;
	localparam int CONV_FRACTIONAL_FORMAT_BIT = 0;
	localparam int CONV_CVD_BIT   = 1;

	// Reset values
	localparam logic [4:0]  COND_RESET  = 5'h00;
	localparam logic [15:0] LIMIT_RESET = 16'h0000;
	localparam logic [15:0] DIFF_RESET  = 16'h0000;
	localparam logic [5:0]  ID_RESET    = 6'h00;
	localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
	localparam logic [11:0] RAW_RESET   = 12'h000;

	// Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [11:0] adr;
		logic [31:0] dat;
	} adcdc_wb_req_s;

	// Wishbone answer to the master
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} adcdc_wb_rsp_s;

	// One conversion from the core
	typedef struct packed {
		logic        valid;
		logic [5:0]  input_id;
		logic        alt;
		logic [5:0]  primary_id;
		logic [11:0] pos;
		logic [11:0] neg;
	} adcdc_conv_s;

	// Whole state of the top module
	typedef struct packed {
		logic        en;
		logic        gien;
		logic [4:0]  cond;
		logic        flag;
		logic [5:0]  id;
		logic [15:0] diff;
		logic [15:0] lo;
		logic [15:0] hi;
		logic        fractional_format;
		logic        differential_capacitive_mode;
		logic        pend;
		logic        ack;
		logic [31:0] dat;
	} adcdc_state_s;

endpackage

// ===== adcdc_result_mem.sv
// Result store: one raw word per analog input, registered read port
`timescale 1ns/1ps
module adcdc_result_mem (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wr_en,
	input  wire logic [5:0]  wr_addr,
	input  wire logic [11:0] wr_data,
	input  wire logic [5:0]  rd_addr,
	output logic      [11:0] rd_data_q
);
	logic [11:0] mem_q [adcdc_pkg::NUM_INPUTS];

	// One entry per input, all zero after reset
	for (genvar i = 0; i < adcdc_pkg::NUM_INPUTS; i++) begin : g_entry
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mem_q[i] <= adcdc_pkg::RAW_RESET;
			end else if (wr_en && (wr_addr == 6'(i))) begin
				mem_q[i] <= wr_data;
			end
		end
	end

	// Registered read, out of range reads as zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_q <= adcdc_pkg::RAW_RESET;
		end else if (rd_addr <= adcdc_pkg::MAX_INPUT) begin
			rd_data_q <= mem_q[rd_addr];
		end else begin
			rd_data_q <= adcdc_pkg::RAW_RESET;
		end
	end
endmodule // adcdc_result_mem

// ===== adcdc_top.sv
// ADC digital comparator and result registers behind a classic Wishbone slave
//
// Function
// - Capture positive minus negative on differential events
// - Captured difference is signed, follows fractional format
// - Event loads watched input number into identifier
// - Normal mode inputs 0-31, differential mode all
// - Identifier binary, never above input 44
// - Enable runs comparator; disable clears event flag
// - Interrupt only while interrupt enable and flag
// - Flag set only by an enabled true condition
// - Flag cleared by identifier read or disable
// - Between condition: low <= result <= high
// - Control bits 15 and 14 read zero
// - Forty-five read-only result words, reset zero
// - Alternate input result goes to primary slot
// - Result reads follow the current fractional format
`timescale 1ns/1ps
module adcdc_top (
	input  wire logic                    CLK_SYS,
	input  wire logic                    RST_N,
	input  wire adcdc_pkg::adcdc_wb_req_s WB_REQ,
	output adcdc_pkg::adcdc_wb_rsp_s      WB_RSP,
	input  wire adcdc_pkg::adcdc_conv_s   CONV,
	output logic                         CMP_IRQ
);
	adcdc_pkg::adcdc_state_s st_q;
	adcdc_pkg::adcdc_state_s st_d;

	logic [5:0]  wr_idx;
	logic        wr_ok;
	logic        eligible;
	logic [15:0] cmp_val;
	logic        cmp_true;
	logic        evt;
	logic [12:0] diff_raw;
	logic [15:0] diff_fmt;
	logic        req_new;
	logic        done;
	logic        hit_res;
	logic [5:0]  rd_idx;
	logic        rd_clr;
	logic [11:0] rd_raw;
	logic [31:0] res_fmt;
	logic [31:0] ctrl_word;
	logic        ctrl_wr;
	logic        cmp_armed;

	// Alternate inputs land in the primary input's slot
	assign wr_idx = CONV.alt ? CONV.primary_id : CONV.input_id;
	assign wr_ok  = CONV.valid && (wr_idx <= adcdc_pkg::MAX_INPUT);

	// Which results the comparator may look at in each mode
	assign eligible = wr_ok && (st_q.differential_capacitive_mode || (wr_idx < adcdc_pkg::NORMAL_LIMIT));

	// Compare the stored integer value against the limits
	assign cmp_val  = {4'h0, CONV.pos};
	assign cmp_true = (st_q.cond[adcdc_pkg::CTRL_BTWN_BIT] && (st_q.lo <= cmp_val) && (cmp_val <= st_q.hi))
		|| (st_q.cond[adcdc_pkg::CTRL_HIHI_BIT] && (cmp_val >= st_q.hi))
		|| (st_q.cond[adcdc_pkg::CTRL_HILO_BIT] && (cmp_val < st_q.hi))
		|| (st_q.cond[adcdc_pkg::CTRL_LOHI_BIT] && (cmp_val >= st_q.lo))
		|| (st_q.cond[adcdc_pkg::CTRL_LOLO_BIT] && (cmp_val < st_q.lo));
	assign evt = eligible && st_q.en && cmp_true;
	assign cmp_armed = eligible && st_q.en && !ctrl_wr;

	// Signed difference, left aligned in fractional format
	assign diff_raw = 13'({1'b0, CONV.pos} - {1'b0, CONV.neg});
	assign diff_fmt = st_q.fractional_format ? {diff_raw, 3'h0} : {{3{diff_raw[12]}}, diff_raw};

	// Result word formatted at read time from the raw store
	assign res_fmt = st_q.fractional_format ? {rd_raw, 20'h00000} : {20'h00000, rd_raw};

	// Bus decode
	assign req_new = WB_REQ.cyc && WB_REQ.stb && !st_q.pend && !st_q.ack;
	assign done    = st_q.pend;
	assign hit_res = (WB_REQ.adr[11:8] == adcdc_pkg::OFS_RESULT_PAGE) && (WB_REQ.adr[1:0] == 2'h0)
		&& (WB_REQ.adr[7:2] <= adcdc_pkg::MAX_INPUT);
	assign rd_idx  = WB_REQ.adr[7:2];
	assign rd_clr  = done && !WB_REQ.we && (WB_REQ.adr == adcdc_pkg::OFS_CMP_CTRL) && WB_REQ.sel[1];
	assign ctrl_wr = done && WB_REQ.we && (WB_REQ.adr == adcdc_pkg::OFS_CMP_CTRL) && WB_REQ.sel[0];

	// Control word as seen by software; bits 15 and 14 stay zero
	assign ctrl_word = {st_q.diff, 2'h0, st_q.id, st_q.en, st_q.gien, st_q.flag, st_q.cond};

	// Raw result store
	adcdc_result_mem adcdc_result_mem_inst (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.wr_en     (wr_ok),
		.wr_addr   (wr_idx),
		.wr_data   (CONV.pos),
		.rd_addr   (rd_idx),
		.rd_data_q (rd_raw)
	);

	// Next state
	always_comb begin
		st_d      = st_q;
		st_d.ack  = 1'b0;
		st_d.pend = req_new;
		if (done) begin
			st_d.ack = 1'b1;
			st_d.dat = adcdc_pkg::DATA_RESET;
			if (WB_REQ.we) begin
				unique case (WB_REQ.adr)
					adcdc_pkg::OFS_CMP_CTRL: begin
						if (WB_REQ.sel[0]) begin
							st_d.en   = WB_REQ.dat[adcdc_pkg::CTRL_EN_BIT];
							st_d.gien = WB_REQ.dat[adcdc_pkg::CTRL_GIEN_BIT];
							st_d.cond = WB_REQ.dat[4:0];
						end
					end
					adcdc_pkg::OFS_LIMITS: begin
						if (WB_REQ.sel[0]) begin
							st_d.lo[7:0] = WB_REQ.dat[7:0];
						end
						if (WB_REQ.sel[1]) begin
							st_d.lo[15:8] = WB_REQ.dat[15:8];
						end
						if (WB_REQ.sel[2]) begin
							st_d.hi[7:0] = WB_REQ.dat[23:16];
						end
						if (WB_REQ.sel[3]) begin
							st_d.hi[15:8] = WB_REQ.dat[31:24];
						end
					end
					adcdc_pkg::OFS_CONV_CTRL: begin
						if (WB_REQ.sel[0]) begin
							st_d.fractional_format = WB_REQ.dat[adcdc_pkg::CONV_FRACTIONAL_FORMAT_BIT];
							st_d.differential_capacitive_mode   = WB_REQ.dat[adcdc_pkg::CONV_CVD_BIT];
						end
					end
					default: begin
					end
				endcase
			end else begin
				if (WB_REQ.adr == adcdc_pkg::OFS_CMP_CTRL) begin
					st_d.dat = ctrl_word;
				end else if (WB_REQ.adr == adcdc_pkg::OFS_LIMITS) begin
					st_d.dat = {st_q.hi, st_q.lo};
				end else if (WB_REQ.adr == adcdc_pkg::OFS_CONV_CTRL) begin
					st_d.dat = {30'h0, st_q.differential_capacitive_mode, st_q.fractional_format};
				end else if (hit_res) begin
					st_d.dat = res_fmt;
				end
			end
		end
		// Event capture; set wins over a read clear, disable always clears
		if (evt) begin
			st_d.id = wr_idx;
			if (st_q.differential_capacitive_mode) begin
				st_d.diff = diff_fmt;
			end
		end
		st_d.flag = st_d.en && (evt || (st_q.flag && !rd_clr));
	end

	// State register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			st_q      <= '0;
			st_q.cond <= adcdc_pkg::COND_RESET;
			st_q.lo   <= adcdc_pkg::LIMIT_RESET;
			st_q.hi   <= adcdc_pkg::LIMIT_RESET;
			st_q.diff <= adcdc_pkg::DIFF_RESET;
			st_q.id   <= adcdc_pkg::ID_RESET;
			st_q.dat  <= adcdc_pkg::DATA_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs
	assign WB_RSP.ack = st_q.ack;
	assign WB_RSP.dat = st_q.dat;
	assign CMP_IRQ    = st_q.flag && st_q.gien;

	// Checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	property p_diff_capture;
		(evt && st_q.differential_capacitive_mode) |=> (st_q.diff == $past(diff_fmt));
	endproperty
	a_diff_capture: assert property (p_diff_capture) else $error("difference not captured on event");

	property p_diff_signed;
		(evt && st_q.differential_capacitive_mode && !st_q.fractional_format && (CONV.neg > CONV.pos)) |=> st_q.diff[15];
	endproperty
	a_diff_signed: assert property (p_diff_signed) else $error("negative difference lost its sign");

	property p_id_load;
		evt |=> (st_q.id == $past(wr_idx)) && (st_q.flag || $past(ctrl_wr));
	endproperty
	a_id_load: assert property (p_id_load) else $error("identifier not loaded on event");

	property p_normal_range;
		(CONV.valid && !st_q.differential_capacitive_mode && (wr_idx >= adcdc_pkg::NORMAL_LIMIT)) |-> !evt;
	endproperty
	a_normal_range: assert property (p_normal_range) else $error("normal mode event on input above 31");

	property p_id_legal;
		st_q.id <= adcdc_pkg::MAX_INPUT;
	endproperty
	a_id_legal: assert property (p_id_legal) else $error("reserved identifier code");

	property p_disable_clears;
		!st_q.en |-> !st_q.flag;
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("flag set while comparator disabled");

	property p_irq;
		CMP_IRQ == (st_q.flag && st_q.gien);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt does not follow flag and enable");

	property p_flag_cause;
		$rose(st_q.flag) |-> $past(evt);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag rose without a true condition");

	property p_read_clear;
		(rd_clr && !evt) |=> !st_q.flag;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("identifier read did not clear flag");

	property p_between;
		(eligible && st_q.en && st_q.cond[adcdc_pkg::CTRL_BTWN_BIT] && (st_q.lo <= cmp_val) && (cmp_val <= st_q.hi)
			&& !ctrl_wr) |=> st_q.flag;
	endproperty
	a_between: assert property (p_between) else $error("between condition missed");

	property p_unimpl;
		(done && !WB_REQ.we && (WB_REQ.adr == adcdc_pkg::OFS_CMP_CTRL)) |=> (WB_RSP.dat[15:14] == 2'h0);
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented control bits not zero");

	property p_ack_pulse;
		st_q.ack |=> !st_q.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

	property p_int_format;
		(done && !WB_REQ.we && hit_res && !st_q.fractional_format) |=> (WB_RSP.dat[31:12] == 20'h00000);
	endproperty
	a_int_format: assert property (p_int_format) else $error("integer result has high bits set");

	property p_alt_slot;
		(CONV.valid && CONV.alt) |-> (wr_idx == CONV.primary_id);
	endproperty
	a_alt_slot: assert property (p_alt_slot) else $error("alternate result not in primary slot");

	property p_ack_latency;
		req_new |=> done ##1 st_q.ack;
	endproperty
	a_ack_latency: assert property (p_ack_latency) else $error("ack not two cycles after request");

	property p_stop;
		!st_q.en |-> !evt;
	endproperty
	a_stop: assert property (p_stop) else $error("event while comparator disabled");

	property p_disable_write;
		(ctrl_wr && !WB_REQ.dat[adcdc_pkg::CTRL_EN_BIT]) |=> !st_q.flag;
	endproperty
	a_disable_write: assert property (p_disable_write) else $error("disable write left flag set");

	property p_no_cond;
		(st_q.cond == adcdc_pkg::COND_RESET) |-> !evt;
	endproperty
	a_no_cond: assert property (p_no_cond) else $error("event with no condition enabled");

	property p_lolo;
		(cmp_armed && st_q.cond[adcdc_pkg::CTRL_LOLO_BIT] && (cmp_val < st_q.lo)) |=> st_q.flag;
	endproperty
	a_lolo: assert property (p_lolo) else $error("below-low condition missed");

	property p_lohi;
		(cmp_armed && st_q.cond[adcdc_pkg::CTRL_LOHI_BIT] && (cmp_val >= st_q.lo)) |=> st_q.flag;
	endproperty
	a_lohi: assert property (p_lohi) else $error("at-or-above-low condition missed");

	property p_hilo;
		(cmp_armed && st_q.cond[adcdc_pkg::CTRL_HILO_BIT] && (cmp_val < st_q.hi)) |=> st_q.flag;
	endproperty
	a_hilo: assert property (p_hilo) else $error("below-high condition missed");

	property p_hihi;
		(cmp_armed && st_q.cond[adcdc_pkg::CTRL_HIHI_BIT] && (cmp_val >= st_q.hi)) |=> st_q.flag;
	endproperty
	a_hihi: assert property (p_hihi) else $error("at-or-above-high condition missed");

	property p_between_miss;
		((st_q.cond == (5'h01 << adcdc_pkg::CTRL_BTWN_BIT)) && ((cmp_val < st_q.lo) || (cmp_val > st_q.hi)))
			|-> !evt;
	endproperty
	a_between_miss: assert property (p_between_miss) else $error("between event outside the limits");

	property p_normal_accept;
		(wr_ok && !st_q.differential_capacitive_mode && (wr_idx < adcdc_pkg::NORMAL_LIMIT) && st_q.en && cmp_true) |-> evt;
	endproperty
	a_normal_accept: assert property (p_normal_accept) else $error("normal mode input ignored");

	property p_cvd_accept;
		(wr_ok && st_q.differential_capacitive_mode && st_q.en && cmp_true) |-> evt;
	endproperty
	a_cvd_accept: assert property (p_cvd_accept) else $error("differential mode input ignored");

	property p_reserved_skip;
		(CONV.valid && (wr_idx > adcdc_pkg::MAX_INPUT)) |-> !evt;
	endproperty
	a_reserved_skip: assert property (p_reserved_skip) else $error("event on a reserved input");

	property p_diff_hold;
		!(evt && st_q.differential_capacitive_mode) |=> $stable(st_q.diff);
	endproperty
	a_diff_hold: assert property (p_diff_hold) else $error("difference changed without an event");

	property p_id_hold;
		!evt |=> $stable(st_q.id);
	endproperty
	a_id_hold: assert property (p_id_hold) else $error("identifier changed without an event");

	property p_id_read;
		(done && !WB_REQ.we && (WB_REQ.adr == adcdc_pkg::OFS_CMP_CTRL))
			|=> (WB_RSP.dat[adcdc_pkg::CTRL_ID_LSB +: 6] == $past(st_q.id));
	endproperty
	a_id_read: assert property (p_id_read) else $error("identifier read back wrong");

	property p_set_wins;
		(rd_clr && evt) |=> st_q.flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("read clear beat a new event");

	property p_fractional_format_format;
		(done && !WB_REQ.we && hit_res && st_q.fractional_format) |=> (WB_RSP.dat == {$past(rd_raw), 20'h00000});
	endproperty
	a_fractional_format_format: assert property (p_fractional_format_format) else $error("fractional result misplaced");

	property p_int_value;
		(done && !WB_REQ.we && hit_res && !st_q.fractional_format) |=> (WB_RSP.dat[11:0] == $past(rd_raw));
	endproperty
	a_int_value: assert property (p_int_value) else $error("integer result value wrong");

	c_event_cvd:   cover property (evt && st_q.differential_capacitive_mode);
	c_read_clear:  cover property (rd_clr && st_q.flag);
	c_irq:         cover property ($rose(CMP_IRQ));
	c_fractional_format_read:  cover property (done && hit_res && st_q.fractional_format);
	c_lolo_event:  cover property (evt && st_q.cond[adcdc_pkg::CTRL_LOLO_BIT]);
endmodule // adcdc_top

// ===== adcdc_core_model.sv
// Behavioural model of the conversion core that feeds results to the comparator
`timescale 1ns/1ps
module adcdc_core_model (
	input  wire logic              clk,
	output adcdc_pkg::adcdc_conv_s conv
);
	// Idle at time zero, no conversion pending
	initial begin
		conv = '0;
	end

	// One conversion after lat idle cycles; fields scramble afterwards
	task automatic convert(input logic [5:0] id, input logic alt, input logic [5:0] prim,
			input logic [11:0] pos, input logic [11:0] neg, input int lat);
		repeat (lat) @(posedge clk);
		conv <= '{1'b1, id, alt, prim, pos, neg};
		@(posedge clk);
		conv <= '{1'b0, ~id, ~alt, ~prim, ~pos, ~neg};
		repeat (2) @(posedge clk);
	endtask
endmodule // adcdc_core_model

// ===== tb_adcdc_top.sv
// Self-checking testbench of the ADC digital comparator and result registers
`timescale 1ns/1ps
module tb_adcdc_top;
	logic                     clk_sys;
	logic                     rst_n;
	adcdc_pkg::adcdc_wb_req_s wb_req;
	adcdc_pkg::adcdc_wb_rsp_s wb_rsp;
	adcdc_pkg::adcdc_conv_s   conv;
	logic                     cmp_irq;
	int                       n_mismatch;
	int                       check_count;
	logic [31:0]              rd;

	adcdc_top adcdc_top_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .WB_REQ(wb_req), .WB_RSP(wb_rsp),
		.CONV(conv), .CMP_IRQ(cmp_irq));
	adcdc_core_model adcdc_core_model_inst (.clk(clk_sys), .conv(conv));

	// 50 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Verdict and end of run
	task automatic close_out();
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Compare a register word
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t word %h expected %h", $time, got, exp);
		end
	endtask

	// Compare the interrupt line
	task automatic chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t irq %b expected %b", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] wd);
		int i;
		@(posedge clk_sys);
		wb_req <= '{1'b1, 1'b1, we, 4'hf, adr, wd};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (wb_rsp.ack === 1'b1) break;
		end
		rd = wb_rsp.dat;
		wb_req <= '{1'b0, 1'b0, 1'b0, 4'h0, 12'h0, 32'h0};
		if (i == 20) begin
			n_mismatch++;
			close_out();
		end
	endtask

	// Read a register and compare it
	task automatic rdc(input logic [11:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		chk32(rd, exp);
	endtask

	// Reset values, unmapped place and unimplemented control bits
	task automatic t_reset();
		rdc(12'h000, 32'h0000_0000);
		rdc(12'h1b0, 32'h0000_0000);
		rdc(12'h0fc, 32'h0000_0000);
		chk1(cmp_irq, 1'b0);
		wb(1'b1, 12'h000, 32'hffff_ffff);
		rdc(12'h000, 32'h0000_00df);
		wb(1'b1, 12'h000, 32'h0);
	endtask

	// Each condition alone: a failing value, then a passing one at its boundary
	task automatic t_cond();
		logic [11:0] good [5] = '{12'h0ff, 12'h100, 12'h1ff, 12'h200, 12'h100};
		logic [11:0] bad [5] = '{12'h100, 12'h0ff, 12'h200, 12'h1ff, 12'h201};
		wb(1'b1, 12'h004, 32'h0200_0100);
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, 12'h000, 32'h80 | (32'h1 << i));
			adcdc_core_model_inst.convert(6'd20, 1'b0, 6'h0, bad[i], 12'h0, i);
			adcdc_core_model_inst.convert(i[5:0], 1'b0, 6'h0, good[i], 12'h0, 0);
			chk1(cmp_irq, 1'b0);
			rdc(12'h000, {18'h0, i[5:0], 8'ha0 | (8'h1 << i)});
		end
	endtask

	// Interrupt follows the flag; disabling clears it and stops the comparator
	task automatic t_irq();
		wb(1'b1, 12'h000, 32'hd0);
		adcdc_core_model_inst.convert(6'd7, 1'b0, 6'h0, 12'h150, 12'h0, 0);
		chk1(cmp_irq, 1'b1);
		wb(1'b1, 12'h000, 32'h50);
		chk1(cmp_irq, 1'b0);
		rdc(12'h000, 32'h0000_0750);
		adcdc_core_model_inst.convert(6'd8, 1'b0, 6'h0, 12'h150, 12'h0, 2);
		rdc(12'h000, 32'h0000_0750);
	endtask

	// Normal mode range, differential capture in both formats
	task automatic t_modes();
		wb(1'b1, 12'h000, 32'h90);
		adcdc_core_model_inst.convert(6'd32, 1'b0, 6'h0, 12'h150, 12'h0, 0);
		rdc(12'h000, 32'h0000_0790);
		wb(1'b1, 12'h008, 32'h2);
		adcdc_core_model_inst.convert(6'd44, 1'b0, 6'h0, 12'h150, 12'h160, 1);
		rdc(12'h000, 32'hfff0_2cb0);
		wb(1'b1, 12'h008, 32'h3);
		adcdc_core_model_inst.convert(6'd44, 1'b0, 6'h0, 12'h150, 12'h160, 0);
		rdc(12'h000, 32'hff80_2cb0);
	endtask

	// Result words: format on read, alternate input slot, read-only
	task automatic t_results();
		rdc(12'h11c, 32'h1500_0000);
		wb(1'b1, 12'h008, 32'h0);
		rdc(12'h11c, 32'h0000_0150);
		adcdc_core_model_inst.convert(6'd40, 1'b1, 6'd3, 12'habc, 12'h0, 0);
		rdc(12'h10c, 32'h0000_0abc);
		rdc(12'h1a0, 32'h0000_0000);
		wb(1'b1, 12'h10c, 32'hffff_ffff);
		rdc(12'h10c, 32'h0000_0abc);
		rdc(12'h1b0, 32'h0000_0150);
	endtask

	// Reset in mid-run clears flag, interrupt, settings and result words
	task automatic t_midreset();
		wb(1'b1, 12'h000, 32'hd0);
		adcdc_core_model_inst.convert(6'd5, 1'b0, 6'h0, 12'h150, 12'h0, 0);
		chk1(cmp_irq, 1'b1);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		chk1(cmp_irq, 1'b0);
		rdc(12'h000, 32'h0000_0000);
		rdc(12'h114, 32'h0000_0000);
	endtask

	// Main sequence
	initial begin
		wb_req = '0;
		rst_n = 1'b0;
		n_mismatch = 0;
		check_count = 0;
		rd = '0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_cond();
		t_irq();
		t_modes();
		t_results();
		t_midreset();
		close_out();
	end
endmodule // tb_adcdc_top
